// File: wsg_wait_state_generator.sv
`timescale 1ns/10ps
// Overview of operation
// - stretch external cycles by zero to fourteen waits
// - all fields zero gates wait counter clock
// - low 15 config bits form five fields
// - multiplier bit scales base count by two
// - reset sets every field to seven
// - bit 15 selects program range, resets zero
// - bits 14..12 cover all i/o space
// - bits 11..9 cover upper data half
// - bits 8..6 cover lower data half
// - bits 5..3 cover upper program range
// - bits 2..0 cover lower program range
// - control bits 15..1 reserved, read zero
// - control bit 0 doubles counts, resets zero
module wsg_wait_state_generator (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // memory-mapped register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_q,
  // external access request
  input  wire logic        acc_start,
  input  wire logic [1:0]  acc_space,
  input  wire logic [22:0] acc_addr,
  // external ready pin
  input  wire logic        ready_pin,
  // access status
  output logic             acc_busy_q,
  output logic             acc_done_q,
  output logic             wait_clk_en_q
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] wait_state_config_q;                  // config register
  logic        wait_multiplier_bit_q;                // control bit 0
  logic [4:0]  wait_cnt_q;                           // remaining waits
  logic [2:0]  ready_sync_q;                         // ready synchroniser
  logic        ready_q;                              // filtered ready level

  // ---------------------------------------------------------------
  // count limits
  // ---------------------------------------------------------------
  localparam logic [4:0] max_base_waits = 5'h07;     // largest undoubled count
  localparam logic [4:0] max_waits      = 5'h0e;     // largest doubled count

  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_count = 3'b010,
    st_ready = 3'b100
  } wsg_state_type;
  wsg_state_type state_q;

  // picks the field for an access
  function automatic logic [2:0] pick_field(input logic [15:0] cfg, input logic [1:0] sp,
                                            input logic [22:0] a);
    logic [2:0] f;
    f = cfg[wsg_pkg::prog_lo_lsb +: wsg_pkg::field_width];
    case (sp)
      wsg_pkg::space_io: begin
        // io space has a single field for the whole span
        f = cfg[wsg_pkg::io_lsb +: wsg_pkg::field_width];
      end
      wsg_pkg::space_data: begin
        // data space is split on its top address bit
        if (a[wsg_pkg::data_half_bit]) begin
          f = cfg[wsg_pkg::data_hi_lsb +: wsg_pkg::field_width];
        end else begin
          f = cfg[wsg_pkg::data_lo_lsb +: wsg_pkg::field_width];
        end
      end
      default: begin
        // range select picks page half or whole-space half
        if (cfg[wsg_pkg::range_sel_bit] ? a[wsg_pkg::ext_half_bit]
                                        : a[wsg_pkg::page_half_bit]) begin
          f = cfg[wsg_pkg::prog_hi_lsb +: wsg_pkg::field_width];
        end else begin
          f = cfg[wsg_pkg::prog_lo_lsb +: wsg_pkg::field_width];
        end
      end
    endcase
    return f;
  endfunction

  // ---------------------------------------------------------------
  // register writes and read data
  // ---------------------------------------------------------------
  // config register, all fields seven after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_state_config_q <= wsg_pkg::config_reset;
    end else if (reg_wr && reg_addr == wsg_pkg::wait_state_config_addr) begin
      wait_state_config_q <= reg_wdata;
    end
  end

  // control register, only the multiplier bit is stored
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_multiplier_bit_q <= wsg_pkg::control_reset[wsg_pkg::mult_bit];
    end else if (reg_wr && reg_addr == wsg_pkg::wait_state_control_addr) begin
      wait_multiplier_bit_q <= reg_wdata[wsg_pkg::mult_bit];
    end
  end

  // read data, reserved control bits read zero, unmapped reads zero
  // the answer follows the address by one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_addr == wsg_pkg::wait_state_config_addr) begin
      reg_rdata_q <= wait_state_config_q;
    end else if (reg_addr == wsg_pkg::wait_state_control_addr) begin
      reg_rdata_q <= {15'h0000, wait_multiplier_bit_q};
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // ready synchroniser
  // ---------------------------------------------------------------
  // three stages; level changes when second and third agree
  // ready idles high so reset does not look like a stall
  always_ff @(posedge clock) begin
    if (rst) begin
      ready_sync_q <= 3'h7;
      ready_q      <= 1'b1;
    end else begin
      ready_sync_q <= {ready_sync_q[1:0], ready_pin};
      if (ready_sync_q[1] == ready_sync_q[2]) begin
        ready_q <= ready_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // clock gate for the wait counter
  // ---------------------------------------------------------------
  // counter enable drops when every field is zero
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_clk_en_q <= 1'b1;
    end else begin
      wait_clk_en_q <= |wait_state_config_q[wsg_pkg::range_sel_bit-1:0];
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  // counts software waits, then holds while ready is low
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q    <= st_idle;
      wait_cnt_q <= 5'h00;
      acc_busy_q <= 1'b0;
      acc_done_q <= 1'b0;
    end else begin
      acc_done_q <= 1'b0;
      case (state_q)
        st_idle: begin
          // requests while busy are never looked at
          if (acc_start) begin
            // base count times one or two
            wait_cnt_q <= {2'h0, pick_field(wait_state_config_q, acc_space, acc_addr)}
                          << wait_multiplier_bit_q;
            acc_busy_q <= 1'b1;
            state_q    <= st_count;
          end
        end
        st_count: begin
          // count runs only while the counter clock is enabled
          if (wait_cnt_q != 5'h00 && wait_clk_en_q) begin
            wait_cnt_q <= wait_cnt_q - 5'h01;
          end else begin
            state_q <= st_ready;
          end
        end
        st_ready: begin
          // slow devices stretch the cycle here
          if (ready_q) begin
            acc_busy_q <= 1'b0;
            acc_done_q <= 1'b1;
            state_q    <= st_idle;
          end
        end
        default: begin
          state_q    <= st_idle;
          acc_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_count_bound: assert property (@(posedge clock) disable iff (rst)
    wait_cnt_q <= max_waits) else $error("wait count above fourteen");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    reg_wr && reg_addr == wsg_pkg::wait_state_control_addr |=> ##1
    reg_addr != wsg_pkg::wait_state_control_addr || reg_rdata_q[15:1] == 15'h0000)
    else $error("reserved control bits not zero");
  chk_gate_off: assert property (@(posedge clock) disable iff (rst)
    wait_state_config_q[wsg_pkg::range_sel_bit-1:0] == '0 |=> !wait_clk_en_q)
    else $error("wait clock not gated");
  chk_done_ready: assert property (@(posedge clock) disable iff (rst)
    acc_done_q |-> $past(ready_q)) else $error("done without ready");
  chk_start_busy: assert property (@(posedge clock) disable iff (rst)
    state_q == st_idle && acc_start |=> acc_busy_q && state_q == st_count)
    else $error("access not started");
  chk_double: assert property (@(posedge clock) disable iff (rst)
    state_q == st_idle && acc_start && !wait_multiplier_bit_q |=> wait_cnt_q <= max_base_waits)
    else $error("undoubled count above seven");
  chk_reset_cfg: assert property (@(posedge clock)
    $past(rst) |-> wait_state_config_q == wsg_pkg::config_reset)
    else $error("config reset wrong");
  chk_ready_wait: assert property (@(posedge clock) disable iff (rst)
    state_q == st_ready && !ready_q |=> acc_busy_q)
    else $error("ready low did not stretch");

  // ---------------------------------------------------------------
  // access sequences
  // ---------------------------------------------------------------
  // an access request taken in idle
  sequence seq_access_taken;
    state_q == st_idle && acc_start;
  endsequence
  // a counted access meeting a ready device
  sequence seq_ready_seen;
    state_q == st_ready && ready_q;
  endsequence
  // an access whose count has not run out
  sequence seq_counting;
    state_q == st_count && wait_cnt_q != 5'h00 && wait_clk_en_q;
  endsequence

  // ---------------------------------------------------------------
  // sequencer checks
  // ---------------------------------------------------------------
  // ready at the end of the count closes the access
  chk_ready_done: assert property (@(posedge clock) disable iff (rst)
    seq_ready_seen |=> acc_done_q && !acc_busy_q && state_q == st_idle)
    else $error("ready did not close access");
  // done lasts a single cycle
  chk_done_pulse: assert property (@(posedge clock) disable iff (rst)
    acc_done_q |=> !acc_done_q)
    else $error("done longer than one cycle");
  // busy stands for the whole access
  chk_busy_level: assert property (@(posedge clock) disable iff (rst)
    state_q != st_idle |-> acc_busy_q)
    else $error("busy low during access");
  // busy is low while idle
  chk_idle_quiet: assert property (@(posedge clock) disable iff (rst)
    state_q == st_idle |-> !acc_busy_q)
    else $error("busy high while idle");
  // one wait per enabled cycle
  chk_count_step: assert property (@(posedge clock) disable iff (rst)
    seq_counting |=> wait_cnt_q == $past(wait_cnt_q) - 5'h01)
    else $error("wait count did not step");
  // doubled counts are always even
  chk_count_even: assert property (@(posedge clock) disable iff (rst)
    seq_access_taken ##0 wait_multiplier_bit_q |=> !wait_cnt_q[0])
    else $error("doubled count is odd");
  // io access loads the io field
  chk_io_field: assert property (@(posedge clock) disable iff (rst)
    seq_access_taken ##0 (acc_space == wsg_pkg::space_io && !wait_multiplier_bit_q) |=>
    wait_cnt_q == {2'h0, $past(wait_state_config_q[wsg_pkg::io_lsb +: wsg_pkg::field_width])})
    else $error("io field not used");
  // lower data access loads the lower data field
  chk_data_lo: assert property (@(posedge clock) disable iff (rst)
    seq_access_taken ##0 (acc_space == wsg_pkg::space_data && !acc_addr[wsg_pkg::data_half_bit]
    && !wait_multiplier_bit_q) |=>
    wait_cnt_q == {2'h0, $past(wait_state_config_q[wsg_pkg::data_lo_lsb +: wsg_pkg::field_width])})
    else $error("lower data field not used");
  // state register keeps a one-hot code
  chk_state_onehot: assert property (@(posedge clock) disable iff (rst)
    $onehot(state_q))
    else $error("state code not one-hot");

  // ---------------------------------------------------------------
  // register checks
  // ---------------------------------------------------------------
  // config write lands whole
  chk_cfg_write: assert property (@(posedge clock) disable iff (rst)
    reg_wr && reg_addr == wsg_pkg::wait_state_config_addr |=> wait_state_config_q == $past(reg_wdata))
    else $error("config write lost");
  // control write stores the multiplier bit
  chk_ctrl_write: assert property (@(posedge clock) disable iff (rst)
    reg_wr && reg_addr == wsg_pkg::wait_state_control_addr |=> wait_multiplier_bit_q == $past(reg_wdata[0]))
    else $error("multiplier write lost");
  // multiplier clear after reset
  chk_reset_ctrl: assert property (@(posedge clock)
    $past(rst) |-> !wait_multiplier_bit_q)
    else $error("multiplier reset wrong");
  // any nonzero field keeps the counter clock running
  chk_gate_on: assert property (@(posedge clock) disable iff (rst)
    wait_state_config_q[wsg_pkg::range_sel_bit-1:0] != '0 |=> wait_clk_en_q)
    else $error("wait clock gated wrongly");
  // filtered ready follows the agreeing stages
  chk_ready_filter: assert property (@(posedge clock) disable iff (rst)
    ready_sync_q[1] == ready_sync_q[2] |=> ready_q == $past(ready_sync_q[2]))
    else $error("ready filter wrong");
endmodule

// File: wsg_pkg.sv
package wsg_pkg;
  // ---------------------------------------------------------------
  // memory-mapped register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] wait_state_config_addr  = 16'h0028;  // config register
  localparam logic [15:0] wait_state_control_addr = 16'h002b;  // control register

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          range_sel_bit      = 15;             // extended program range select
  localparam int          io_lsb             = 12;             // i/o field
  localparam int          data_hi_lsb        = 9;              // upper data field
  localparam int          data_lo_lsb        = 6;              // lower data field
  localparam int          prog_hi_lsb        = 3;              // upper program field
  localparam int          prog_lo_lsb        = 0;              // lower program field
  localparam int          mult_bit           = 0;              // multiplier bit in control
  localparam int          field_width        = 3;              // width of one field
  localparam logic [15:0] config_reset       = 16'h7fff;       // all fields seven, select clear
  localparam logic [15:0] control_reset      = 16'h0000;       // multiplier clear
  localparam int          data_half_bit      = 15;             // splits data space in halves
  localparam int          page_half_bit      = 15;             // splits each 64k page
  localparam int          ext_half_bit       = 22;             // splits 8m program space

  // ---------------------------------------------------------------
  // access spaces
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    space_prog = 2'h0,
    space_data = 2'h1,
    space_io   = 2'h2
  } wsg_space_type;
endpackage

// File: wsg_ext_device.sv
`timescale 1ns/10ps
// -------------------------------------------------------------
// slow external device: holds ready low at the start of access
// -------------------------------------------------------------
module wsg_ext_device (
  // clock
  input  wire logic       clock,
  // access status from the generator
  input  wire logic       acc_busy_q,
  // cycles that ready stays low after the access begins
  input  wire logic [7:0] hold_cycles,
  // ready line, pulled up outside accesses
  output logic            ready_pin
);
  logic [7:0] busy_cnt_q;  // cycles since the access began

  // count cycles of the current access
  always_ff @(posedge clock) begin
    if (!acc_busy_q) begin
      busy_cnt_q <= 8'h00;
    end else if (busy_cnt_q != 8'hff) begin
      busy_cnt_q <= busy_cnt_q + 8'h01;
    end
  end

  // stretch the access past the programmed count
  assign ready_pin = !(acc_busy_q && (busy_cnt_q < hold_cycles));
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
  logic        clock = 1'b0;     // machine clock
  logic        rst = 1'b1;       // sync reset
  logic [15:0] reg_addr = 16'h0000;
  logic        reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata_q;
  logic        acc_start = 1'b0;
  logic [1:0]  acc_space = 2'h0;
  logic [22:0] acc_addr = 23'h000000;
  logic        ready_pin;
  logic        acc_busy_q;
  logic        acc_done_q;
  logic        wait_clk_en_q;
  logic [7:0]  hold_cycles = 8'h00;  // delay of the slow device
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cnt;

  always #50 clock = ~clock;

  wsg_wait_state_generator dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .acc_start(acc_start), .acc_space(acc_space),
    .acc_addr(acc_addr), .ready_pin(ready_pin), .acc_busy_q(acc_busy_q), .acc_done_q(acc_done_q),
    .wait_clk_en_q(wait_clk_en_q));
  wsg_ext_device ext (.clock(clock), .acc_busy_q(acc_busy_q), .hold_cycles(hold_cycles),
    .ready_pin(ready_pin));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #5 reg_wr = 1'b0;
    @(posedge clock);
    #5;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_addr = a;
    @(posedge clock);
    #5 check({16'h0000, reg_rdata_q}, {16'h0000, exp}, "read data");
  endtask

  // one access; cnt gets the edges from the taking edge to done
  task automatic acc(input logic [1:0] sp, input logic [22:0] ad);
    acc_space = sp;
    acc_addr = ad;
    acc_start = 1'b1;
    @(posedge clock);
    #5 acc_start = 1'b0;
    check(acc_busy_q, 1'b1, "busy after start");
    cnt = 0;
    while (acc_done_q !== 1'b1 && cnt < 100) begin
      @(posedge clock);
      #5 cnt++;
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // accesses under two configurations and their base counts
  logic [1:0]  sp_t[7] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [22:0] ad_t[7] = '{23'h7ffff0, 23'h008000, 23'h007fff, 23'h018000, 23'h417fff, 23'h400000, 23'h3f8000};
  int          n_t[7] = '{1, 2, 3, 4, 5, 4, 5};

  initial begin
    #300000;
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clock);
    #5 rst = 1'b0;
    rd(16'h0028, 16'h7fff);
    rd(16'h002b, 16'h0000);
    rd(16'h0029, 16'h0000);
    check(wait_clk_en_q, 1'b1, "clock enable after reset");
    acc(2'h0, 23'h000000);
    check(cnt, 7 + 2, "reset wait count");
    // distinct field values, range select clear then set
    wr(16'h0028, 16'h14e5);
    for (int i = 0; i < 7; i++) begin
      if (i == 5) wr(16'h0028, 16'h94e5);
      acc(sp_t[i], ad_t[i]);
      check(cnt, n_t[i] + 2, "field wait count");
    end
    // multiplier set, reserved bits ignored
    wr(16'h002b, 16'hffff);
    rd(16'h002b, 16'h0001);
    acc(2'h1, 23'h008000);
    check(cnt, 4 + 2, "doubled count");
    wr(16'h0028, 16'h7fff);
    acc(2'h0, 23'h400000);
    check(cnt, 14 + 2, "longest count");
    // slow device keeps ready low beyond the count
    hold_cycles = 8'h18;
    acc(2'h2, 23'h001234);
    check(cnt > 14 + 2, 1'b1, "ready stretch");
    hold_cycles = 8'h00;
    // all fields zero gates the counter clock
    wr(16'h002b, 16'h0000);
    wr(16'h0028, 16'h8000);
    @(posedge clock);
    #5 check(wait_clk_en_q, 1'b0, "clock gated");
    acc(2'h1, 23'h000010);
    check(cnt, 2, "zero wait count");
    wr(16'h0028, 16'h0001);
    @(posedge clock);
    #5 check(wait_clk_en_q, 1'b1, "clock running");
    end_sim();
  end
endmodule
